// *** rtl/dsc_regs.vh ***
// Purpose: register map and field constants for the decoder status and input config bank
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: register offsets are local choices; data sits in the low bits
//
// Function
// R01 - mode status copies control mode request bit
// R02 - form from request or header by auto bit
// R03 - mode/form pair encodes sector type
// R04 - uncorrectable conditions force form status to one
// R05 - two-bit next-frame form preview with error bit
// R06 - mode preview bits ored with erasure flag
// R07 - preview top bit marks mode above seven
// R08 - reading validity status clears decoder interrupt
// R09 - invalid flag in bit seven after reads
// R10 - bit five shows correction performed
// R11 - reset register write reinitialises, sets host mode
// R12 - hardware reset loads host select 111
// R13 - tri-state pins float after reset unless read strobe; code floats them after hardware reset even with strobe low
// R14 - host select decode of three modes
// R15 - ten-bit subcode address in low/high registers
// R16 - bit seven selects serial input format
// R17 - bits six/five select oversampling factor
// R18 - bit four selects subcode input format
// R19 - bit three switches subcode port on
// R20 - bit two selects raw subcode
// R21 - bit one enters buffer ram test
// R22 - subcode timing uses oversampling from config
// R23 - erasure flag comes from erasure input
// R24 - reserved bits read zero, writes ignored
`ifndef DSC_REGS_VH
`define DSC_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DSC_FRAME_STATUS_OFS  12'h000
`define DSC_VALID_STATUS_OFS  12'h004
`define DSC_SOFT_RESET_OFS    12'h008
`define DSC_SUB_ADDR_L_OFS    12'h00c
`define DSC_SUB_ADDR_H_OFS    12'h010
`define DSC_INPUT_CFG_OFS     12'h014
`define DSC_CONTROL_ONE_OFS   12'h018
`define DSC_CONTROL_ZERO_OFS  12'h01c
`define DSC_DECODER_STAT_OFS  12'h020

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DSC_DECODER_CONTROL_ONE_MODE_BIT    3
`define DSC_DECODER_CONTROL_ONE_FORM_BIT    2
`define DSC_DECODER_CONTROL_ONE_MCHK_BIT    1
`define DSC_DECODER_CONTROL_ZERO_AUTO_BIT    0
`define DSC_VALID_BIT         7
`define DSC_CORRECTION_DONE_FLAG_BIT          5
`define DSC_HSEL_RESET        3'h7
`define DSC_HSEL_COMPAT_A     3'h0
`define DSC_HSEL_ATAPI        3'h1
`define DSC_HSEL_COMPAT_B     3'h2
`define DSC_HSEL_UNKNOWN      3'h3
`define DSC_INCFG_MASK        8'hfe
`define DSC_SUB_H_MASK        8'h03

`endif

// *** rtl/dsc_status_config.v ***
// Purpose: decoder status, soft reset/host select, subcode address and input path config
// Assumes: decoder core delivers frame events and header bytes on pclk
// Notes: apb slave answers with no wait states; unmapped reads return zero with pslverr
`timescale 1ns/1ps
`default_nettype none
`include "dsc_regs.vh"

module dsc_status_config (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // decoder core events, one-cycle pulses at frame end
  input  wire        frame_done,
  input  wire        ecc_performed,
  input  wire        illegal_sync_flag,
  input  wire        long_block_flag,
  input  wire        submode_error,
  input  wire        mode_mismatch,
  input  wire        mode_byte_error,
  input  wire        form2_detected,
  input  wire        hdr_form_bit,
  // next block header preview
  input  wire        next_hdr_valid,
  input  wire [7:0]  next_mode_byte,
  input  wire        next_form_bit,
  input  wire        next_form_err,
  // erasure pin from disc decoder
  input  wire        erasure_input,
  // host pin
  input  wire        host_read_strobe_n,
  // outputs
  output reg         decoder_interrupt,
  output wire        soft_reset_pulse,
  output wire [2:0]  host_select,
  output wire        host_mode_compat_a,
  output wire        host_mode_atapi,
  output wire        host_mode_compat_b,
  output wire        host_pins_oe,
  output wire [9:0]  subcode_block_address,
  output wire        serial_format_select,
  output wire [2:0]  oversample_factor,
  output wire        subcode_input_format,
  output wire        subcode_port_enable,
  output wire        subcode_raw_select,
  output wire        buffer_ram_test
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [1:0] era_sync_q;
  reg [1:0] hrd_sync_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      era_sync_q <= 2'h0;
      hrd_sync_q <= 2'h3;
    end else begin
      era_sync_q <= {era_sync_q[0], erasure_input};
      hrd_sync_q <= {hrd_sync_q[0], host_read_strobe_n};
    end
  end

  // R23 erasure flag source
  wire erasure_flag = era_sync_q[1];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;

  function is_ofs;
    input [11:0] a;
    input [11:0] o;
    begin
      is_ofs = (a == o);
    end
  endfunction

  wire hit_frame = is_ofs(paddr, `DSC_FRAME_STATUS_OFS);
  wire hit_valid = is_ofs(paddr, `DSC_VALID_STATUS_OFS);
  wire hit_reset = is_ofs(paddr, `DSC_SOFT_RESET_OFS);
  wire hit_subl  = is_ofs(paddr, `DSC_SUB_ADDR_L_OFS);
  wire hit_subh  = is_ofs(paddr, `DSC_SUB_ADDR_H_OFS);
  wire hit_incfg = is_ofs(paddr, `DSC_INPUT_CFG_OFS);
  wire hit_ctl1  = is_ofs(paddr, `DSC_CONTROL_ONE_OFS);
  wire hit_ctl0  = is_ofs(paddr, `DSC_CONTROL_ZERO_OFS);
  wire hit_dstat = is_ofs(paddr, `DSC_DECODER_STAT_OFS);
  wire hit_any   = hit_frame | hit_valid | hit_reset | hit_subl | hit_subh
                 | hit_incfg | hit_ctl1 | hit_ctl0 | hit_dstat;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // R11 write to reset register
  wire soft_rst = wr_en & hit_reset;
  assign soft_reset_pulse = soft_rst;

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  reg [2:0] hsel_q;
  reg [7:0] ctl1_q;
  reg       ctl0_auto_q;
  reg [9:0] sub_addr_q;
  reg [7:0] incfg_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // R12 hardware reset host select
      hsel_q      <= `DSC_HSEL_RESET;
      ctl1_q      <= 8'h00;
      ctl0_auto_q <= 1'b0;
      sub_addr_q  <= 10'h000;
      incfg_q     <= 8'h00;
    end else if (soft_rst) begin
      // R11 reinit and adopt mode
      hsel_q      <= pwdata[2:0];
      ctl1_q      <= 8'h00;
      ctl0_auto_q <= 1'b0;
      sub_addr_q  <= 10'h000;
      incfg_q     <= 8'h00;
    end else if (wr_en) begin
      if (hit_ctl1) begin
        ctl1_q <= pwdata[7:0];
      end
      if (hit_ctl0) begin
        ctl0_auto_q <= pwdata[`DSC_DECODER_CONTROL_ZERO_AUTO_BIT];
      end
      // R15 ten-bit split address
      if (hit_subl) begin
        sub_addr_q[7:0] <= pwdata[7:0];
      end
      if (hit_subh) begin
        sub_addr_q[9:8] <= pwdata[1:0];
      end
      // R24 reserved bit dropped
      if (hit_incfg) begin
        incfg_q <= pwdata[7:0] & `DSC_INCFG_MASK;
      end
    end
  end

  // ----------------------------------------
  // current frame status
  // ----------------------------------------
  reg form_q;
  reg correction_done_flag_q;
  reg valid_bad_q;
  reg [3:0] rmod_q;
  reg [1:0] rform_q;

  // R06 preview from mode byte and erasure
  wire [3:0] rmod_d = {(|next_mode_byte[7:3]) | erasure_flag,
                       next_mode_byte[2:0] | {3{erasure_flag}}};

  // R04 forced uncorrectable conditions
  wire force_form = illegal_sync_flag | long_block_flag | form2_detected | submode_error
                  | (ctl1_q[`DSC_DECODER_CONTROL_ONE_MCHK_BIT] & (mode_mismatch | mode_byte_error));

  // R02 form source selection
  wire req_form = ctl0_auto_q ? hdr_form_bit : ctl1_q[`DSC_DECODER_CONTROL_ONE_FORM_BIT];

  wire stat_rd = rd_en & hit_valid;
  wire frame_rd = rd_en & hit_frame;

  // ----------------------------------------
  // decoder register read tracking
  // ----------------------------------------
  reg seen_frame_q;

  // R09 invalid at reset, otherwise only after the frame status and then the validity status were read;
  // a read that races a new frame saw stale data, so the frame clears it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_frame_q <= 1'b0;
    end else if (soft_rst | frame_done) begin
      seen_frame_q <= 1'b0;
    end else if (frame_rd) begin
      seen_frame_q <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      form_q            <= 1'b0;
      correction_done_flag_q            <= 1'b0;
      valid_bad_q       <= 1'b1;
      rmod_q            <= 4'h0;
      rform_q           <= 2'h0;
      decoder_interrupt <= 1'b0;
    end else if (soft_rst) begin
      form_q            <= 1'b0;
      correction_done_flag_q            <= 1'b0;
      valid_bad_q       <= 1'b1;
      rmod_q            <= 4'h0;
      rform_q           <= 2'h0;
      decoder_interrupt <= 1'b0;
    end else begin
      if (frame_done) begin
        // R04 force beats requested form
        form_q      <= req_form | force_form;
        // R10 correction performed flag
        correction_done_flag_q      <= ecc_performed;
        // R09 valid after new frame
        valid_bad_q <= 1'b0;
      end else if (stat_rd & seen_frame_q) begin
        // R09 invalid once read out
        valid_bad_q <= 1'b1;
      end
      // R08 read clears, new event wins
      if (frame_done) begin
        decoder_interrupt <= 1'b1;
      end else if (stat_rd) begin
        decoder_interrupt <= 1'b0;
      end
      if (next_hdr_valid) begin
        rmod_q  <= rmod_d;
        // R05 form preview with error bit
        rform_q <= {next_form_err, next_form_bit & ~next_form_err};
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // R01 R03 R07 mode copy and pair encoding
  wire [7:0] frame_status = {rmod_q, ctl1_q[`DSC_DECODER_CONTROL_ONE_MODE_BIT], form_q, rform_q};
  wire [7:0] valid_status = {valid_bad_q, 1'b0, correction_done_flag_q, 5'h00};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      // R24 reserved reads zero
      case (1'b1)
        hit_frame: begin
          prdata <= {24'h000000, frame_status};
        end
        hit_valid: begin
          prdata <= {24'h000000, valid_status};
        end
        hit_subl: begin
          prdata <= {24'h000000, sub_addr_q[7:0]};
        end
        hit_subh: begin
          prdata <= {30'h00000000, sub_addr_q[9:8]};
        end
        hit_incfg: begin
          prdata <= {24'h000000, incfg_q};
        end
        hit_ctl1: begin
          prdata <= {24'h000000, ctl1_q};
        end
        hit_ctl0: begin
          prdata <= {31'h00000000, ctl0_auto_q};
        end
        hit_dstat: begin
          prdata <= {29'h00000000, hsel_q};
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // host mode and input path outputs
  // ----------------------------------------
  assign host_select = hsel_q;

  function hsel_is;
    input [2:0] sel;
    input [2:0] code;
    begin
      hsel_is = (sel == code);
    end
  endfunction

  // next host select, same priority as the register update
  reg [2:0] hsel_d;

  always @* begin
    hsel_d = hsel_q;
    if (soft_rst) begin
      hsel_d = pwdata[2:0];
    end
  end

  reg mode_a_q;
  reg mode_atapi_q;
  reg mode_b_q;

  // decodes flopped from the next value so they never lag host_select
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_a_q     <= 1'b0;
      mode_atapi_q <= 1'b0;
      mode_b_q     <= 1'b0;
    end else begin
      // R14 host select decode
      mode_a_q     <= hsel_is(hsel_d, `DSC_HSEL_COMPAT_A);
      mode_atapi_q <= hsel_is(hsel_d, `DSC_HSEL_ATAPI);
      mode_b_q     <= hsel_is(hsel_d, `DSC_HSEL_COMPAT_B);
    end
  end

  assign host_mode_compat_a = mode_a_q;
  assign host_mode_atapi    = mode_atapi_q;
  assign host_mode_compat_b = mode_b_q;
  // R13 float pins unless read strobe low; reserved and unknown modes float too
  assign host_pins_oe = (mode_a_q | mode_atapi_q | mode_b_q) & ~hrd_sync_q[1];

  // ----------------------------------------
  // oversampling factor
  // ----------------------------------------
  function [2:0] ovs_decode;
    input [1:0] code;
    begin
      case (code)
        2'h1: begin
          ovs_decode = 3'h2;
        end
        2'h2: begin
          ovs_decode = 3'h4;
        end
        default: begin
          ovs_decode = 3'h1;
        end
      endcase
    end
  endfunction

  reg [2:0] ovs_q;

  // one cycle behind the config write; subcode timing tolerates it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovs_q <= 3'h1;
    end else begin
      ovs_q <= ovs_decode(incfg_q[6:5]);
    end
  end

  assign subcode_block_address = sub_addr_q;
  // R16 serial format select
  assign serial_format_select = incfg_q[7];
  // R17 R22 oversample factor, code 11 treated as none
  assign oversample_factor = ovs_q;
  // R18 subcode input format
  assign subcode_input_format = incfg_q[4];
  // R19 subcode port enable
  assign subcode_port_enable  = incfg_q[3];
  // R20 raw subcode select
  assign subcode_raw_select   = incfg_q[2];
  // R21 buffer ram test
  assign buffer_ram_test      = incfg_q[1];

endmodule // dsc_status_config
`default_nettype wire

// *** test/dsc_props.sv ***
// Purpose: port assertions for the status and config bank
// Assumes: zero-wait apb, two-stage pin synchronisers
// Notes: bound below the module
`timescale 1ns/1ps
`default_nettype none
`include "dsc_regs.vh"
module dsc_props (
  // clock, reset and apb
  input wire logic pclk, input wire logic presetn, input wire logic psel, input wire logic penable,
  input wire logic pwrite, input wire logic [11:0] paddr, input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // decoder and host side
  input wire logic frame_done, input wire logic host_read_strobe_n, input wire logic decoder_interrupt,
  input wire logic [2:0] host_select, input wire logic host_pins_oe,
  input wire logic [9:0] subcode_block_address, input wire logic serial_format_select
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic rd3;
  assign wr = psel & penable & pwrite;
  assign rd3 = psel & penable & !pwrite & (paddr == `DSC_VALID_STATUS_OFS);
  chk_irq_set: assert property (frame_done |=> decoder_interrupt) else $error("irq not set");
  chk_irq_clear: assert property (rd3 && !frame_done |=> !decoder_interrupt) else $error("irq kept");
  chk_hsel_load: assert property (wr && paddr == `DSC_SOFT_RESET_OFS |=> host_select == $past(pwdata[2:0]))
    else $error("host select");
  chk_oe_float: assert property (host_select > `DSC_HSEL_COMPAT_B |-> !host_pins_oe) else $error("pins on");
  chk_oe_strobe: assert property (host_pins_oe |-> !$past(host_read_strobe_n, 2)) else $error("oe early");
  chk_unmapped: assert property (psel && penable && paddr > `DSC_DECODER_STAT_OFS |-> pslverr)
    else $error("no slverr");
  chk_sub_hold: assert property (!wr |=> $stable(subcode_block_address)) else $error("sub moved");
  chk_serial_fmt: assert property (wr && paddr == `DSC_INPUT_CFG_OFS |=> serial_format_select == $past(pwdata[7]))
    else $error("format bit");
  cov_frame: cover property (frame_done);
  cov_irq_read: cover property (rd3 && decoder_interrupt);
  cov_soft_rst: cover property (wr && paddr == `DSC_SOFT_RESET_OFS);
endmodule // dsc_props
bind dsc_status_config dsc_props chk_u (.*);
`default_nettype wire

// *** test/dsc_core_model.sv ***
// Purpose: decoder core stand-in that ends frames on request
// Assumes: event levels count only with the frame-end pulse
// Notes: levels invert outside the pulse so a stale sample shows
`timescale 1ns/1ps
`default_nettype none
module dsc_core_model (
  // request and frame outputs
  input wire logic pclk, input wire logic go, input wire logic [7:0] ev,
  output var logic frame_done, output logic [7:0] lv
);
  initial frame_done = 1'b0;
  always @(posedge pclk) begin
    frame_done <= go;
  end
  assign lv = frame_done ? ev : ~ev;
endmodule // dsc_core_model
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: self-checking bench for the status and config bank
// Assumes: zero-wait apb
// Notes: lfsr stimulus from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "dsc_regs.vh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, hrd_n = 0;
  logic ers = 0, nv = 0, nfb = 0, nfe = 0, oe, irq, fd, prdy, perr, se;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] r = 16'h5141;
  logic [7:0] ev = 0, nm = 0, lv, m;
  logic [2:0] hsel, ovs, hm;
  logic [9:0] sub;
  logic [4:0] cfg;
  int error_cnt = 0, n_compared = 0;
  initial forever #2.5 pclk = ~pclk;
  dsc_status_config dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(prdy), .pslverr(perr),
    .frame_done(fd), .ecc_performed(lv[0]), .illegal_sync_flag(lv[1]), .long_block_flag(lv[2]),
    .submode_error(lv[3]), .mode_mismatch(lv[4]), .mode_byte_error(lv[5]), .form2_detected(lv[6]),
    .hdr_form_bit(lv[7]), .next_hdr_valid(nv), .next_mode_byte(nm), .next_form_bit(nfb),
    .next_form_err(nfe), .erasure_input(ers), .host_read_strobe_n(hrd_n), .decoder_interrupt(irq),
    .soft_reset_pulse(), .host_select(hsel), .host_mode_compat_a(hm[2]), .host_mode_atapi(hm[1]),
    .host_mode_compat_b(hm[0]), .host_pins_oe(oe), .subcode_block_address(sub),
    .serial_format_select(cfg[4]), .oversample_factor(ovs), .subcode_input_format(cfg[3]),
    .subcode_port_enable(cfg[2]), .subcode_raw_select(cfg[1]), .buffer_ram_test(cfg[0]));
  dsc_core_model core_u (.pclk(pclk), .go(go), .ev(ev), .frame_done(fd), .lv(lv));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // apb master: waits for pready, no fixed latency assumed
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (prdy !== 1'b1 && n++ < 64);
    if (n >= 64) error_cnt++;
    rd = prdata;
    se = perr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task automatic frame(input logic [7:0] e);
    ev <= e;
    go <= 1;
    @(posedge pclk);
    go <= 0;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (9000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    #1;
    cmp("hsel", 7, hsel);
    cmp("oe", 0, oe);
    for (int i = 0; i < 4; i++) begin
      bus(1, `DSC_SOFT_RESET_OFS, 'hf8 | i);
      repeat (3) @(posedge pclk);
      #1;
      cmp("hsel", i, hsel);
      cmp("hmod", {i == 0, i == 1, i == 2}, hm);
      cmp("oe", i < 3, oe);
    end
    $display("host test done");
    for (int k = 0; k < 4; k++) begin
      r = lfsr(r);
      bus(1, `DSC_INPUT_CFG_OFS, {r[7], k[1:0], r[4:0]});
      bus(0, `DSC_INPUT_CFG_OFS, 0);
      cmp("cfg", {r[7], k[1:0], r[4:1], 1'b0}, rd);
      cmp("pins", {r[7], r[4:1]}, cfg);
      cmp("ovs", k == 1 ? 2 : k == 2 ? 4 : 1, ovs);
    end
    bus(1, `DSC_SUB_ADDR_L_OFS, r[15:8]);
    bus(1, `DSC_SUB_ADDR_H_OFS, r[7:0]);
    cmp("sub", {r[1:0], r[15:8]}, sub);
    bus(1, `DSC_SOFT_RESET_OFS, 1);
    cmp("init", 0, {sub, cfg});
    repeat (3) @(posedge pclk);
    #1;
    cmp("oe", 1, oe);
    hrd_n <= 1;
    repeat (3) @(posedge pclk);
    #1;
    cmp("oe", 0, oe);
    hrd_n <= 0;
    $display("config test done");
    for (int j = 0; j < 4; j++) begin
      bus(1, `DSC_CONTROL_ONE_OFS, 8 + 4 * j[0]);
      bus(1, `DSC_CONTROL_ZERO_OFS, j[1]);
      frame({!j[0], 7'h01});
      bus(0, `DSC_FRAME_STATUS_OFS, 0);
      cmp("mf", {1'b1, j[1] ? !j[0] : j[0]}, rd[3:2]);
      cmp("irq", 1, irq);
      bus(0, `DSC_VALID_STATUS_OFS, 0);
      cmp("val", 'h20, rd);
      cmp("slverr", 0, se);
      cmp("irq", 0, irq);
    end
    bus(1, `DSC_CONTROL_ONE_OFS, 2);
    bus(1, `DSC_CONTROL_ZERO_OFS, 0);
    for (int b = 0; b < 7; b++) begin
      frame(8'(1 << b));
      bus(0, `DSC_FRAME_STATUS_OFS, 0);
      cmp("mf", b > 0, rd[3:2]);
    end
    bus(0, `DSC_VALID_STATUS_OFS, 0);
    bus(0, `DSC_VALID_STATUS_OFS, 0);
    cmp("inv", 1, rd[7]);
    for (int k = 0; k < 4; k++) begin
      r = lfsr(r);
      m = k == 0 ? 8'h07 : k == 1 ? 8'h08 : r[7:0];
      ers <= k == 3;
      repeat (3) @(posedge pclk);
      nm <= m;
      nfb <= r[8];
      nfe <= k == 2;
      nv <= 1;
      @(posedge pclk);
      nv <= 0;
      nm <= ~m;
      bus(0, `DSC_FRAME_STATUS_OFS, 0);
      cmp("mprv", {|m[7:3] | ers, m[2:0] | {3{ers}}}, rd[7:4]);
      cmp("fprv", nfe ? 2 : nfb, rd[1:0]);
    end
    bus(0, 12'h100, 0);
    cmp("unmap", 0, rd);
    cmp("slverr", 1, se);
    $display("status test done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire
